// file: msa_pkg.sv
// msa_pkg: constants and carrier types for the sonde adapter register bank.
// assumes: one 125 MHz clock; holding registers addressed by register number.
package msa_pkg;

    // ************************************************************
    // holding register numbers
    // ************************************************************
    localparam logic [15:0] REG_SAMPLE_INTERVAL = 16'h0001;
    localparam logic [15:0] REG_WIPE_TRIGGER = 16'h0003;
    localparam logic [15:0] REG_CODE_FIRST = 16'h0081;
    localparam logic [15:0] REG_CODE_LAST = 16'h00a0;
    localparam logic [15:0] REG_RESULT_FIRST = 16'h0181;
    localparam logic [15:0] REG_RESULT_LAST = 16'h01c0;
    localparam int NUM_PARAMS = 32;
    localparam logic [15:0] CODE_END = 16'h0000;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int NS_PER_SEC = 1000000000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int TICKS_PER_SEC = NS_PER_SEC / CLK_PERIOD_NS;
    localparam int IDLE_LIMIT_SEC = 60;
    localparam int WIPE_TIME_SEC = 60;
    localparam int WIPE_BEFORE_MIN = 2;
    localparam int SEC_PER_MIN = 60;
    localparam int WIPE_BEFORE_SEC = WIPE_BEFORE_MIN * SEC_PER_MIN;

    // ************************************************************
    // scaled-integer ranges, in units of 1/10000
    // ************************************************************
    localparam int SCALE_DIV = 10000;
    localparam logic signed [31:0] SC_NEG50 = -32'sd500000;
    localparam logic signed [31:0] SC_605_35 = 32'sd6053500;
    localparam logic signed [31:0] SC_ZERO = 32'sd0;
    localparam logic signed [31:0] SC_655_35 = 32'sd6553500;
    localparam logic signed [31:0] SC_65535 = 32'sd655350000;
    localparam logic signed [31:0] SC_65_535 = 32'sd655350;
    localparam logic signed [31:0] SC_6553_5 = 32'sd65535000;
    localparam logic signed [31:0] SC_6_5535 = 32'sd65535;
    localparam logic signed [31:0] SC_NEG1638_4 = -32'sd16384000;
    localparam logic signed [31:0] SC_1638_35 = 32'sd16383500;
    localparam logic signed [31:0] SC_NEG27_768 = -32'sd277680;
    localparam logic signed [31:0] SC_39_767 = 32'sd397670;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } msa_req_t;

    typedef struct packed {
        logic [4:0] slot;
        logic [31:0] value;
    } msa_sample_t;

    typedef struct packed {
        logic has_range;
        logic signed [31:0] low;
        logic signed [31:0] high;
    } msa_scale_t;

endpackage

// file: msa_scale_rom.sv
// msa_scale_rom: parameter code to scaled-integer range lookup.
// assumes: purely combinational; the caller registers the result.
`timescale 1ns/100ps
module msa_scale_rom (
    input wire logic [15:0] i_code,
    output msa_pkg::msa_scale_t o_scale
);

    // ************************************************************
    // lookup, grouped by shared range
    // ************************************************************
    always_comb begin
        o_scale = '0;
        o_scale.has_range = 1'b1;
        case (i_code)
            16'h0001, 16'h0002, 16'h0014, 16'h0015, 16'h0016, 16'h0017,
            16'h00f0, 16'h00f1: begin
                o_scale.low = msa_pkg::SC_NEG50;
                o_scale.high = msa_pkg::SC_605_35;
            end
            16'h0003, 16'h0004, 16'h0006, 16'h002f, 16'h0030, 16'h006a,
            16'h0070, 16'h00c1, 16'h00c2, 16'h00d3, 16'h00d6, 16'h00d8,
            16'h00da, 16'h00e1, 16'h00e2, 16'h00e3, 16'h00e4,
            16'h00ed: begin
                o_scale.low = msa_pkg::SC_ZERO;
                o_scale.high = msa_pkg::SC_655_35;
            end
            16'h0005, 16'h0007, 16'h006e, 16'h00ee: begin
                o_scale.low = msa_pkg::SC_ZERO;
                o_scale.high = msa_pkg::SC_65535;
            end
            16'h000a, 16'h000c, 16'h001c, 16'h005f, 16'h00d4, 16'h00e5,
            16'h00e6, 16'h00ef: begin
                o_scale.low = msa_pkg::SC_ZERO;
                o_scale.high = msa_pkg::SC_65_535;
            end
            16'h0011, 16'h0013, 16'h0065, 16'h006c, 16'h0091: begin
                o_scale.low = msa_pkg::SC_NEG1638_4;
                o_scale.high = msa_pkg::SC_1638_35;
            end
            16'h0012: begin
                o_scale.low = msa_pkg::SC_NEG27_768;
                o_scale.high = msa_pkg::SC_39_767;
            end
            16'h0025, 16'h00be, 16'h00cc, 16'h00df: begin
                o_scale.low = msa_pkg::SC_ZERO;
                o_scale.high = msa_pkg::SC_6553_5;
            end
            16'h00bf: begin
                o_scale.low = msa_pkg::SC_ZERO;
                o_scale.high = msa_pkg::SC_6_5535;
            end
            // dates, times and unknown codes carry no range
            default: begin
                o_scale.has_range = 1'b0;
            end
        endcase
    end

endmodule

// file: msa_regs.sv
// msa_regs: holding-register bank of the sonde adapter, with idle sleep,
// periodic sonde refresh, wipe trigger and result storage.
// assumes: register accesses arrive as single-cycle strobes; the sonde
// side returns readings through i_sample and ends a refresh with i_done.
`timescale 1ns/100ps
module msa_regs #(
    parameter int TICKS_PER_SEC = msa_pkg::TICKS_PER_SEC,
    parameter int NUM_PARAMS = msa_pkg::NUM_PARAMS
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input msa_pkg::msa_req_t i_req,
    output logic [15:0] o_reg_rdata,
    output logic o_reg_rvalid,
    input wire logic i_sample_valid,
    input msa_pkg::msa_sample_t i_sample,
    input wire logic i_done,
    input wire logic [4:0] i_scale_sel,
    output logic o_sample_req,
    output logic o_sample_wipe,
    output logic o_wipe_req,
    output logic o_wipe_busy,
    output logic o_asleep,
    output logic [5:0] o_param_count,
    output msa_pkg::msa_scale_t o_scale
);

    localparam int TICK_W = $clog2(TICKS_PER_SEC);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICKS_PER_SEC - 1);
    localparam logic [6:0] IDLE_LAST = 7'(msa_pkg::IDLE_LIMIT_SEC);
    localparam logic [6:0] WIPE_SECS = 7'(msa_pkg::WIPE_TIME_SEC);
    localparam logic [15:0] WIPE_BEFORE = 16'(msa_pkg::WIPE_BEFORE_SEC);

    typedef struct packed {
        logic [TICK_W-1:0] tick_cnt;
        logic [15:0] interval;
        logic [15:0] sample_cnt;
        logic [6:0] idle_cnt;
        logic asleep;
        logic [6:0] wipe_cnt;
        logic pending;
        logic sample_req;
        logic sample_wipe;
        logic wipe_req;
        logic [15:0] rdata;
        logic rvalid;
        msa_pkg::msa_scale_t scale;
        logic [NUM_PARAMS-1:0][15:0] codes;
        logic [NUM_PARAMS-1:0][31:0] results;
    } msa_state_t;

    msa_state_t st_r;
    msa_state_t st_nxt;
    msa_pkg::msa_scale_t scale_lut;
    logic [5:0] count;

    // ************************************************************
    // decode helpers
    // ************************************************************
    function automatic logic in_span(input logic [15:0] a,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
        in_span = (a >= lo) && (a <= hi);
    endfunction

    // number of codes ahead of the first zero code
    function automatic logic [5:0] map_len(
        input logic [NUM_PARAMS-1:0][15:0] c);
        logic stop;
        map_len = '0;
        stop = 1'b0;
        for (int i = 0; i < NUM_PARAMS; i++) begin
            if (c[i] == msa_pkg::CODE_END) begin
                stop = 1'b1;
            end
            if (!stop) begin
                map_len = map_len + 6'h01;
            end
        end
    endfunction

    assign count = map_len(st_r.codes);

    msa_scale_rom u_rom (
        .i_code(st_r.codes[i_scale_sel]),
        .o_scale(scale_lut)
    );

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic sec_tick;
        logic query;
        logic [15:0] off;
        logic [4:0] idx;
        sec_tick = 1'b0;
        query = 1'b0;
        off = '0;
        idx = '0;
        st_nxt = st_r;
        st_nxt.sample_req = 1'b0;
        st_nxt.wipe_req = 1'b0;
        st_nxt.rvalid = 1'b0;
        st_nxt.scale = scale_lut;

        // one-second time base
        if (st_r.tick_cnt == TICK_LAST) begin
            st_nxt.tick_cnt = '0;
            sec_tick = 1'b1;
        end else begin
            st_nxt.tick_cnt = st_r.tick_cnt + TICK_W'(1);
        end

        query = i_req.rd || i_req.wr;

        // idle sleep: queries and autonomous refreshes keep it awake
        if (query) begin
            st_nxt.idle_cnt = '0;
            st_nxt.asleep = 1'b0;
        end else if (sec_tick && !st_r.asleep) begin
            if (st_r.idle_cnt == IDLE_LAST - 7'h01) begin
                st_nxt.asleep = 1'b1;
                st_nxt.idle_cnt = '0;
            end else begin
                st_nxt.idle_cnt = st_r.idle_cnt + 7'h01;
            end
        end

        // periodic refresh
        if (st_r.interval != '0) begin
            if (sec_tick) begin
                if (st_r.sample_cnt >= st_r.interval - 16'h0001) begin
                    st_nxt.sample_cnt = '0;
                    st_nxt.sample_req = 1'b1;
                    st_nxt.pending = 1'b1;
                    st_nxt.asleep = 1'b0;
                    st_nxt.idle_cnt = '0;
                end else begin
                    st_nxt.sample_cnt = st_r.sample_cnt + 16'h0001;
                end
            end
        end else begin
            st_nxt.sample_cnt = '0;
            // one refresh per query burst, not one per register read
            if (query && !st_r.pending) begin
                st_nxt.sample_req = 1'b1;
                st_nxt.pending = 1'b1;
            end
        end
        st_nxt.sample_wipe = (st_r.interval > WIPE_BEFORE);

        // a new request outranks a completion in the same cycle
        if (i_done && !st_nxt.sample_req) begin
            st_nxt.pending = 1'b0;
        end

        // wipe status window
        if (sec_tick && st_r.wipe_cnt != '0) begin
            st_nxt.wipe_cnt = st_r.wipe_cnt - 7'h01;
        end

        // sonde readings, dropped beyond the end of the map
        if (i_sample_valid && (6'(i_sample.slot) < count)) begin
            st_nxt.results[i_sample.slot] = i_sample.value;
        end

        // host writes
        if (i_req.wr) begin
            if (i_req.addr == msa_pkg::REG_SAMPLE_INTERVAL) begin
                st_nxt.interval = i_req.wdata;
                st_nxt.sample_cnt = '0;
            end else if (i_req.addr == msa_pkg::REG_WIPE_TRIGGER) begin
                st_nxt.wipe_req = 1'b1;
                st_nxt.wipe_cnt = WIPE_SECS;
            end else if (in_span(i_req.addr, msa_pkg::REG_CODE_FIRST,
                                 msa_pkg::REG_CODE_LAST)) begin
                off = i_req.addr - msa_pkg::REG_CODE_FIRST;
                st_nxt.codes[off[4:0]] = i_req.wdata;
            end
        end

        // host reads; unmapped and write-only registers read zero
        if (i_req.rd) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = '0;
            if (i_req.addr == msa_pkg::REG_SAMPLE_INTERVAL) begin
                st_nxt.rdata = st_r.interval;
            end else if (in_span(i_req.addr, msa_pkg::REG_CODE_FIRST,
                                 msa_pkg::REG_CODE_LAST)) begin
                off = i_req.addr - msa_pkg::REG_CODE_FIRST;
                st_nxt.rdata = st_r.codes[off[4:0]];
            end else if (in_span(i_req.addr, msa_pkg::REG_RESULT_FIRST,
                                 msa_pkg::REG_RESULT_LAST)) begin
                off = i_req.addr - msa_pkg::REG_RESULT_FIRST;
                idx = off[5:1];
                if (off[0]) begin
                    st_nxt.rdata = st_r.results[idx][31:16];
                end else begin
                    st_nxt.rdata = st_r.results[idx][15:0];
                end
            end
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_reg_rdata = st_r.rdata;
    assign o_reg_rvalid = st_r.rvalid;
    assign o_sample_req = st_r.sample_req;
    assign o_sample_wipe = st_r.sample_wipe;
    assign o_wipe_req = st_r.wipe_req;
    assign o_wipe_busy = (st_r.wipe_cnt != '0);
    assign o_asleep = st_r.asleep;
    assign o_param_count = count;
    assign o_scale = st_r.scale;

endmodule

// file: msa_regs_sva.sv
// msa_regs_sva: port-level timing checks for the register bank.
// assumes: bound into msa_regs; one clock, sync active-low reset.
`timescale 1ns/100ps
module msa_regs_chk #(
    parameter int TICKS_PER_SEC = msa_pkg::TICKS_PER_SEC
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input msa_pkg::msa_req_t i_req,
    input wire logic o_reg_rvalid,
    input wire logic o_sample_req,
    input wire logic o_sample_wipe,
    input wire logic o_wipe_req,
    input wire logic o_wipe_busy,
    input wire logic o_asleep
);
    // wide counts: a full-speed second overflows int after 17 seconds
    localparam longint LIM = 61 * longint'(TICKS_PER_SEC) + 2;
    localparam longint LOW = 59 * longint'(TICKS_PER_SEC);
    logic [15:0] ivl_r;
    longint idle_r;
    wire logic qry = i_req.rd | i_req.wr;

    // ****************
    // shadow of interval and idle span
    // ****************
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            ivl_r <= 16'h0000;
            idle_r <= 0;
        end else begin
            if (i_req.wr && i_req.addr == msa_pkg::REG_SAMPLE_INTERVAL)
                ivl_r <= i_req.wdata;
            // a refresh also keeps the adapter awake
            if (qry || o_sample_req)
                idle_r <= 0;
            else if (idle_r < LIM)
                idle_r <= idle_r + 1;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    chk_read_answer: assert property (
        i_req.rd |=> o_reg_rvalid) else $error("read not answered");
    chk_wipe_start: assert property (
        i_req.wr && i_req.addr == msa_pkg::REG_WIPE_TRIGGER
        |=> o_wipe_req && o_wipe_busy) else $error("wipe not started");
    chk_wipe_cause: assert property (
        o_wipe_req |-> $past(i_req.wr)
        && $past(i_req.addr) == msa_pkg::REG_WIPE_TRIGGER)
        else $error("wipe without write");
    chk_wake_query: assert property (
        qry |=> !o_asleep) else $error("query did not wake");
    chk_sleep_late: assert property (
        $rose(o_asleep) |-> idle_r >= LOW) else $error("slept too soon");
    chk_sleep_due: assert property (
        // a periodic refresh wakes the adapter one edge before the
        // shadow count sees its request
        idle_r == LIM |-> o_asleep || o_sample_req)
        else $error("sleep missed");
    chk_manual_only: assert property (
        ivl_r == 16'h0000 && o_sample_req |-> $past(qry))
        else $error("refresh without query");
    chk_wipe_flag: assert property (
        o_sample_req && $stable(ivl_r)
        |-> o_sample_wipe == (ivl_r > 16'h0078))
        else $error("wipe flag wrong");
endmodule

bind msa_regs msa_regs_chk #(.TICKS_PER_SEC(TICKS_PER_SEC)) u_chk (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_req(i_req),
    .o_reg_rvalid(o_reg_rvalid), .o_sample_req(o_sample_req),
    .o_sample_wipe(o_sample_wipe), .o_wipe_req(o_wipe_req),
    .o_wipe_busy(o_wipe_busy), .o_asleep(o_asleep));

// file: msa_sonde_model.sv
// msa_sonde_model: behavioural sonde answering refresh requests.
// assumes: request is a clocked pulse; answers are driven off negedge.
`timescale 1ns/100ps
module msa_sonde_model (
    input wire logic i_clock,
    input wire logic i_req,
    input wire logic i_slow,
    output logic o_valid,
    output msa_pkg::msa_sample_t o_sample,
    output logic o_done
);
    localparam logic [31:0] VALS [4] = '{32'h41c8e147, 32'h404147ae,
        32'h40e75c29, 32'h3fb9999a};

    initial begin
        o_valid = 1'b0;
        o_done = 1'b0;
        o_sample = '0;
        forever begin
            @(negedge i_clock);
            if (i_req) begin
                repeat (i_slow ? 20 : 1) @(negedge i_clock);
                // slot 3 is sent on purpose: past the map end
                for (int n = 0; n < 4; n++) begin
                    o_valid = 1'b1;
                    o_sample = {5'(n), VALS[n]};
                    @(negedge i_clock);
                end
                o_valid = 1'b0;
                // scrambled so a stale reading never looks valid
                o_sample = ~o_sample;
                o_done = 1'b1;
                @(negedge i_clock);
                o_done = 1'b0;
            end
        end
    end
endmodule

// file: modbus_sonde_adapter_regs_bench.sv
// bench: directed checks of the sonde adapter register bank.
// assumes: msa_regs with a shortened second; sonde model on far side.
`timescale 1ns/100ps
module modbus_sonde_adapter_regs_bench;
    localparam int T = 10;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    msa_pkg::msa_req_t req = '0;
    logic [4:0] sel = 5'h00;
    logic slow = 1'b0;
    logic [15:0] rdata;
    logic rvalid, s_valid, done, s_req, s_wipe, w_req, busy, asleep;
    logic [5:0] cnt;
    msa_pkg::msa_sample_t smp;
    msa_pkg::msa_scale_t scale;
    int n_fail = 0;
    int total_checks = 0;

    msa_regs #(.TICKS_PER_SEC(T)) uut (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_req(req),
        .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .i_sample_valid(s_valid), .i_sample(smp), .i_done(done),
        .i_scale_sel(sel), .o_sample_req(s_req), .o_sample_wipe(s_wipe),
        .o_wipe_req(w_req), .o_wipe_busy(busy), .o_asleep(asleep),
        .o_param_count(cnt), .o_scale(scale));
    msa_sonde_model sonde (
        .i_clock(i_clock), .i_req(s_req), .i_slow(slow),
        .o_valid(s_valid), .o_sample(smp), .o_done(done));

    initial forever #4 i_clock = ~i_clock;

    // ****************
    // shared tasks
    // ****************
    task automatic chk(input logic [64:0] got, input logic [64:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge i_clock);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge i_clock);
        req.wr = 1'b0;
    endtask
    task automatic rdc(input logic [15:0] a, input logic [15:0] e);
        @(negedge i_clock);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge i_clock);
        req.rd = 1'b0;
        chk({rvalid, rdata}, {1'b1, e});
    endtask
    task automatic wait_for(ref logic s, input logic v, input int lim);
        int k;
        for (k = 0; k < lim && s !== v; k++)
            @(negedge i_clock);
        chk(s, v);
    endtask
    task automatic results;
        $display("checks=%0d fails=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ****************
    // scenarios
    // ****************
    task automatic t_regs;
        rdc(16'h0001, 16'h0000);
        wr(16'h0001, 16'h00a5);
        rdc(16'h0001, 16'h00a5);
        wr(16'h0001, 16'h0000);
        rdc(16'h0003, 16'h0000);
        rdc(16'h0005, 16'h0000);
        wr(16'h0181, 16'h1234);
        rdc(16'h0181, 16'h0000);
    endtask
    task automatic t_codes;
        wr(16'h0081, 16'h0001);
        wr(16'h0082, 16'h0012);
        wr(16'h0083, 16'h0033);
        wr(16'h0085, 16'h0005);
        chk(cnt, 6'h03);
        @(negedge i_clock);
        chk(scale, {1'b1, msa_pkg::SC_NEG50, msa_pkg::SC_605_35});
        sel = 5'h01;
        @(negedge i_clock);
        chk(scale, {1'b1, msa_pkg::SC_NEG27_768, msa_pkg::SC_39_767});
        sel = 5'h02;
        @(negedge i_clock);
        chk(scale, 65'h0);
    endtask
    task automatic t_results;
        repeat (10) @(negedge i_clock);
        slow = 1'b1;
        rdc(16'h0001, 16'h0000);
        chk(s_req, 1'b1);
        rdc(16'h0001, 16'h0000);
        chk(s_req, 1'b0);
        slow = 1'b0;
        repeat (30) @(negedge i_clock);
        rdc(16'h0181, 16'he147);
        rdc(16'h0182, 16'h41c8);
        rdc(16'h0185, 16'h5c29);
        rdc(16'h0187, 16'h0000);
    endtask
    task automatic t_wipe;
        wr(16'h0003, 16'h5a5a);
        chk({w_req, busy}, 2'b11);
        @(negedge i_clock);
        chk(w_req, 1'b0);
        repeat (58 * T) @(negedge i_clock);
        chk(busy, 1'b1);
        wait_for(busy, 1'b0, 3 * T);
    endtask
    task automatic t_sleep;
        rdc(16'h0001, 16'h0000);
        repeat (50 * T) @(negedge i_clock);
        rdc(16'h0001, 16'h0000);
        repeat (50 * T) @(negedge i_clock);
        chk(asleep, 1'b0);
        wait_for(asleep, 1'b1, 12 * T);
        rdc(16'h0001, 16'h0000);
        chk(asleep, 1'b0);
    endtask
    task automatic t_period;
        int hits;
        wr(16'h0001, 16'h0002);
        repeat (10) @(negedge i_clock);
        wait_for(s_req, 1'b1, 2 * T + 2);
        chk(s_wipe, 1'b0);
        repeat (2 * T - 1) @(negedge i_clock);
        chk(s_req, 1'b0);
        @(negedge i_clock);
        chk(s_req, 1'b1);
        // host polls at twice the refresh period
        for (int r = 0; r < 2; r++) begin
            hits = 0;
            repeat (4 * T) begin
                @(negedge i_clock);
                hits += s_req;
            end
            chk(hits, 2);
            rdc(16'h0181, 16'he147);
        end
        // realign so the next write never meets a refresh edge
        wait_for(s_req, 1'b1, 2 * T + 2);
        wr(16'h0001, 16'h0079);
        wait_for(s_req, 1'b1, 121 * T + 2);
        chk(s_wipe, 1'b1);
        wr(16'h0001, 16'h0000);
    endtask

    initial begin
        repeat (3) @(negedge i_clock);
        i_rst_n = 1'b1;
        t_regs;
        t_codes;
        t_results;
        t_wipe;
        t_sleep;
        t_period;
        results;
    end
    initial begin
        repeat (20000) @(posedge i_clock);
        n_fail++;
        results;
    end
endmodule
